// >>> logic/bacd_decoder.sv
`timescale 1ns/1ns
`include "bacd_defines.svh"
module bacd_decoder
    import bacd_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_req_valid,
    input wire bacd_req_t i_req,
    output bacd_state_t o_dec
);

    bacd_state_t st_q;
    bacd_state_t st_d;
    logic prior_bit;

    assign prior_bit = i_req.opnd_val[i_req.bit_idx];

    always_comb begin
        logic mem;
        logic is_bit;
        logic is_cmp;
        logic [3:0] ext;
        logic [3:0] base_b;
        logic [4:0] reg_c;
        logic [4:0] mem_c;
        logic signed [15:0] v;
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        logic signed [15:0] imm;
        logic [15:0] res;
        logic wide;
        mem = 1'b1;
        wide = 1'b0;
        is_bit = 1'b0;
        is_cmp = 1'b0;
        ext = 4'h0;
        base_b = 4'h0;
        reg_c = 5'h00;
        mem_c = 5'h00;
        v = 16'sh0000;
        lo = 16'sh0000;
        hi = 16'sh0000;
        imm = 16'sh0000;
        res = 16'h0000;
        st_d = st_q;
        st_d.valid = 1'b0;
        if (i_req_valid) begin
            st_d = '0;
            st_d.valid = 1'b1;
            st_d.opnd = BACD_OPND_NONE;
            case (i_req.op)
                BACD_BREAK_TRAP: begin
                    base_b = `BACD_BRK_B;
                    reg_c = i_req.via_table ? `BACD_BRK_C + `BACD_BRK_VT_C : `BACD_BRK_C;
                    mem_c = reg_c;
                end
                BACD_BIT_SET_OP, BACD_BIT_TEST_OP: begin
                    is_bit = 1'b1;
                    base_b = `BACD_BIT_B;
                    reg_c = `BACD_BIT_RC;
                    mem_c = `BACD_BIT_MC;
                end
                BACD_BIT_TEST_CLEAR_OP, BACD_BIT_TEST_SET_OP: begin
                    is_bit = 1'b1;
                    base_b = `BACD_RMW_B;
                    reg_c = `BACD_RMW_RC;
                    mem_c = `BACD_RMW_MC;
                end
                BACD_BIT_EXOR_OP: begin
                    is_bit = 1'b1;
                    base_b = `BACD_BIT_EXOR_OP_B;
                    reg_c = `BACD_BIT_EXOR_OP_RC;
                    mem_c = `BACD_BIT_EXOR_OP_MC;
                end
                BACD_RANGE_LIMIT_OP: begin
                    st_d.word = (i_req.word == `BACD_SIZE_WORD);
                    base_b = st_d.word ? `BACD_RANGE_LIMIT_OP_B + `BACD_RANGE_LIMIT_OP_W_B : `BACD_RANGE_LIMIT_OP_B;
                    reg_c = `BACD_RANGE_LIMIT_OP_RC;
                    mem_c = `BACD_RANGE_LIMIT_OP_MC;
                end
                BACD_COMPARE_OP_G: begin
                    is_cmp = 1'b1;
                    st_d.word = (i_req.word == `BACD_SIZE_WORD);
                    base_b = st_d.word ? `BACD_CMPG_B + `BACD_CMP_W_B : `BACD_CMPG_B;
                    reg_c = `BACD_CMPG_RC;
                    mem_c = `BACD_CMPG_MC;
                end
                BACD_COMPARE_OP_L: begin
                    is_cmp = 1'b1;
                    base_b = `BACD_CMPL_B;
                    reg_c = `BACD_CMPL_RC;
                    mem_c = `BACD_CMPL_MC;
                end
                BACD_COMPARE_OP_Q: begin
                    is_cmp = 1'b1;
                    st_d.word = (i_req.word == `BACD_SIZE_WORD);
                    base_b = `BACD_CMPQ_B;
                    reg_c = `BACD_CMPQ_RC;
                    mem_c = `BACD_CMPQ_MC;
                end
                default: begin
                    st_d.illegal = 1'b1;
                end
            endcase
            // operand field; break trap carries none
            if (i_req.op == BACD_BREAK_TRAP) begin
                mem = 1'b0;
            end else begin
                st_d.alt_base = i_req.field[0];
                case (i_req.field[4:1])
                    `BACD_GRP_IND: st_d.opnd = BACD_OPND_IND_AREG;
                    `BACD_GRP_AREG: begin
                        mem = 1'b0;
                        st_d.opnd = i_req.field[0] ? BACD_OPND_ADDR_REG_ONE : BACD_OPND_ADDR_REG_ZERO;
                    end
                    `BACD_GRP_D8A, `BACD_GRP_D8B: begin
                        ext = `BACD_EXT_S;
                        st_d.opnd = (i_req.field[4:1] == `BACD_GRP_D8A) ? BACD_OPND_DISP_AREG : BACD_OPND_DISP_BASE;
                    end
                    `BACD_GRP_D16A, `BACD_GRP_D16B: begin
                        ext = `BACD_EXT_M;
                        st_d.opnd = (i_req.field[4:1] == `BACD_GRP_D16A) ? BACD_OPND_DISP_AREG : BACD_OPND_DISP_BASE;
                    end
                    `BACD_GRP_D24A: begin
                        ext = `BACD_EXT_L;
                        st_d.opnd = BACD_OPND_DISP_AREG;
                    end
                    `BACD_GRP_ABS: begin
                        ext = (i_req.field[0] == `BACD_ABS_SHORT) ? `BACD_EXT_M : `BACD_EXT_L;
                        st_d.opnd = BACD_OPND_ABS;
                    end
                    default: begin
                        mem = 1'b0;
                        case (i_req.field)
                            `BACD_F_R0L: st_d.opnd = (i_req.op == BACD_COMPARE_OP_L) ?
                                BACD_OPND_REG_PAIR_TWO_ZERO : BACD_OPND_DATA_REG_ZERO_LOW;
                            `BACD_F_R1L: st_d.opnd = (i_req.op == BACD_COMPARE_OP_L) ?
                                BACD_OPND_REG_PAIR_THREE_ONE : BACD_OPND_DATA_REG_ONE_LOW;
                            `BACD_F_R0H: begin
                                st_d.opnd = BACD_OPND_DATA_REG_ZERO_HIGH;
                                st_d.illegal = (i_req.op == BACD_COMPARE_OP_L);
                            end
                            `BACD_F_R1H: begin
                                st_d.opnd = BACD_OPND_DATA_REG_ONE_HIGH;
                                st_d.illegal = (i_req.op == BACD_COMPARE_OP_L);
                            end
                            default: st_d.illegal = 1'b1;
                        endcase
                    end
                endcase
            end
            // bit operands use 11/19/27-bit bases, others 8/16/24-bit offsets
            case (ext)
                `BACD_EXT_S: st_d.disp_bits = is_bit ? `BACD_BIT_DISP_S : `BACD_CMP_DISP_S;
                `BACD_EXT_M: st_d.disp_bits = is_bit ? `BACD_BIT_DISP_M : `BACD_CMP_DISP_M;
                `BACD_EXT_L: st_d.disp_bits = is_bit ? `BACD_BIT_DISP_L : `BACD_CMP_DISP_L;
                default: st_d.disp_bits = 5'h00;
            endcase
            st_d.bytes = base_b + ext;
            st_d.cycles = mem ? mem_c : reg_c;
            // prefix only means something ahead of a compare
            if (is_cmp && i_req.first_byte == `BACD_PREFIX_IND) begin
                st_d.indirect = 1'b1;
                st_d.bytes = base_b + ext + `BACD_IND_B;
                st_d.cycles = (mem ? mem_c : reg_c) + `BACD_IND_C;
            end
            st_d.quick_imm = {{4{i_req.quick_immediate_field[3]}}, i_req.quick_immediate_field};
            // datapath; byte operations work on sign-extended low bytes
            // 32-bit compare ignores the size bit and works on the full low half
            wide = st_d.word || (i_req.op == BACD_COMPARE_OP_L);
            v = wide ? i_req.opnd_val : {{8{i_req.opnd_val[7]}}, i_req.opnd_val[7:0]};
            lo = wide ? i_req.lim_lo : {{8{i_req.lim_lo[7]}}, i_req.lim_lo[7:0]};
            hi = wide ? i_req.lim_hi : {{8{i_req.lim_hi[7]}}, i_req.lim_hi[7:0]};
            imm = (i_req.op == BACD_COMPARE_OP_Q) ? {{8{st_d.quick_imm[7]}}, st_d.quick_imm} : lo;
            res = i_req.opnd_val;
            case (i_req.op)
                BACD_BIT_SET_OP: begin
                    res[i_req.bit_idx] = 1'b1;
                    st_d.flag = prior_bit;
                end
                BACD_BIT_TEST_OP: st_d.flag = prior_bit;
                BACD_BIT_TEST_CLEAR_OP, BACD_BIT_TEST_SET_OP: begin
                    // flag and write-back leave in the same cycle, nothing can interleave
                    st_d.flag = prior_bit;
                    res[i_req.bit_idx] = (i_req.op == BACD_BIT_TEST_SET_OP);
                end
                BACD_BIT_EXOR_OP: st_d.flag = i_req.carry ^ prior_bit;
                BACD_RANGE_LIMIT_OP: begin
                    if (v < lo) begin
                        res = lo;
                    end else if (v > hi) begin
                        res = hi;
                    end else begin
                        res = v;
                    end
                end
                BACD_COMPARE_OP_G, BACD_COMPARE_OP_L, BACD_COMPARE_OP_Q: begin
                    // only the low 16 bits of a 32-bit compare are evaluated here
                    res = v - imm;
                    st_d.flag = (v == imm);
                end
                default: res = i_req.opnd_val;
            endcase
            st_d.result = res;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_dec = st_q;

    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_take(bacd_op_t o);
        i_req_valid && i_req.op == o;
    endsequence

    sequence s_regdst;
        i_req.field == `BACD_F_R0L;
    endsequence

    AST_BRK_TIME: assert property (s_take(BACD_BREAK_TRAP) |=> o_dec.bytes == `BACD_BRK_B &&
        o_dec.cycles == ($past(i_req.via_table) ? `BACD_BRK_C + `BACD_BRK_VT_C : `BACD_BRK_C))
        else $error("break trap length or cycles wrong");

    AST_BIT_SET_REG: assert property (s_take(BACD_BIT_SET_OP) ##0 s_regdst |=> o_dec.valid &&
        o_dec.bytes == `BACD_BIT_B && o_dec.cycles == `BACD_BIT_RC
        && o_dec.opnd == BACD_OPND_DATA_REG_ZERO_LOW)
        else $error("bit set register form wrong");

    AST_RMW_MEM: assert property (s_take(BACD_BIT_TEST_CLEAR_OP) ##0 i_req.field[4:1] == `BACD_GRP_IND
        |=> o_dec.bytes == `BACD_RMW_B && o_dec.cycles == `BACD_RMW_MC)
        else $error("test-and-clear memory form wrong");

    AST_BIT_EXOR_OP_D24: assert property (s_take(BACD_BIT_EXOR_OP) ##0 i_req.field[4:1] == `BACD_GRP_D24A
        |=> o_dec.bytes == `BACD_BIT_EXOR_OP_B + `BACD_EXT_L && o_dec.cycles == `BACD_BIT_EXOR_OP_MC
        && o_dec.disp_bits == `BACD_BIT_DISP_L)
        else $error("bit exclusive-or long form wrong");

    AST_RANGE_LIMIT_OP_WORD: assert property (s_take(BACD_RANGE_LIMIT_OP) ##0 i_req.word ##0 s_regdst
        |=> o_dec.bytes == `BACD_RANGE_LIMIT_OP_B + `BACD_RANGE_LIMIT_OP_W_B && o_dec.cycles == `BACD_RANGE_LIMIT_OP_RC && o_dec.word)
        else $error("word range_limit_op length wrong");

    AST_CMP_IND: assert property (s_take(BACD_COMPARE_OP_G) ##0 !i_req.word
        && i_req.first_byte == `BACD_PREFIX_IND && i_req.field[4:1] == `BACD_GRP_D8B
        |=> o_dec.indirect && o_dec.cycles == `BACD_CMPG_MC + `BACD_IND_C
        && o_dec.bytes == `BACD_CMPG_B + `BACD_EXT_S + `BACD_IND_B)
        else $error("indirect compare length or cycles wrong");

    AST_CMPL_PAIR: assert property (s_take(BACD_COMPARE_OP_L) ##0 i_req.field == `BACD_F_R0H
        |=> o_dec.illegal)
        else $error("32-bit compare took an unassigned register");

    AST_QUICK_IMM: assert property (s_take(BACD_COMPARE_OP_Q)
        |=> $signed(o_dec.quick_imm) == $signed($past(i_req.quick_immediate_field)))
        else $error("quick immediate sign extension wrong");

    AST_RMW_FLAG: assert property (s_take(BACD_BIT_TEST_SET_OP)
        |=> o_dec.flag == $past(prior_bit) && o_dec.result[$past(i_req.bit_idx)])
        else $error("test-and-set lost prior bit or did not set");

    AST_RANGE_LIMIT_OP_RANGE: assert property (s_take(BACD_RANGE_LIMIT_OP) ##0 i_req.word
        && $signed(i_req.lim_lo) <= $signed(i_req.lim_hi)
        |=> $signed(o_dec.result) >= $signed($past(i_req.lim_lo))
        && $signed(o_dec.result) <= $signed($past(i_req.lim_hi)))
        else $error("range_limit_op result outside its bounds");

    AST_SIZE: assert property (s_take(BACD_COMPARE_OP_G) |=> o_dec.word == $past(i_req.word))
        else $error("size bit not honoured");

    sequence s_plain;
        i_req.first_byte != `BACD_PREFIX_IND;
    endsequence

    sequence s_abs_short;
        i_req.field == {`BACD_GRP_ABS, `BACD_ABS_SHORT};
    endsequence

    AST_CMPL_R31: assert property (s_take(BACD_COMPARE_OP_L) ##0 i_req.field == `BACD_F_R1L
        |=> !o_dec.illegal && o_dec.opnd == BACD_OPND_REG_PAIR_THREE_ONE)
        else $error("32-bit compare lost its second register pair");

    AST_CMPQ_REG: assert property (s_take(BACD_COMPARE_OP_Q) ##0 s_plain ##0 s_regdst
        |=> o_dec.bytes == `BACD_CMPQ_B && o_dec.cycles == `BACD_CMPQ_RC && !o_dec.indirect)
        else $error("quick compare register form wrong");

    AST_CMPG_ABS: assert property (s_take(BACD_COMPARE_OP_G) ##0 s_plain ##0 !i_req.word ##0 s_abs_short
        |=> o_dec.bytes == `BACD_CMPG_B + `BACD_EXT_M && o_dec.cycles == `BACD_CMPG_MC
        && o_dec.disp_bits == `BACD_CMP_DISP_M && o_dec.opnd == BACD_OPND_ABS)
        else $error("compare short absolute form wrong");

    AST_BIT_ABS: assert property (s_take(BACD_BIT_TEST_OP) ##0 s_abs_short
        |=> o_dec.bytes == `BACD_BIT_B + `BACD_EXT_M && o_dec.cycles == `BACD_BIT_MC
        && o_dec.disp_bits == `BACD_BIT_DISP_M)
        else $error("bit test short absolute form wrong");

    // prefix byte ahead of a bit op is not an indirection
    AST_PREFIX_BIT: assert property (s_take(BACD_BIT_SET_OP) ##0 i_req.first_byte == `BACD_PREFIX_IND
        |=> !o_dec.indirect)
        else $error("prefix taken on a bit operation");

    AST_IND_REG: assert property (s_take(BACD_COMPARE_OP_Q) ##0 i_req.first_byte == `BACD_PREFIX_IND
        ##0 s_regdst
        |=> o_dec.indirect && o_dec.cycles == `BACD_CMPQ_RC + `BACD_IND_C
        && o_dec.bytes == `BACD_CMPQ_B + `BACD_IND_B)
        else $error("indirect register compare length or cycles wrong");

    AST_DREG_MAP: assert property (s_take(BACD_BIT_TEST_OP) ##0 i_req.field == `BACD_F_R1H
        |=> o_dec.opnd == BACD_OPND_DATA_REG_ONE_HIGH && !o_dec.illegal && o_dec.cycles == `BACD_BIT_RC)
        else $error("register bit code mapped wrong");

    AST_CMPL_MEM: assert property (s_take(BACD_COMPARE_OP_L) ##0 s_plain
        ##0 i_req.field[4:1] == `BACD_GRP_D16B
        |=> o_dec.bytes == `BACD_CMPL_B + `BACD_EXT_M && o_dec.cycles == `BACD_CMPL_MC)
        else $error("32-bit compare memory form wrong");

endmodule : bacd_decoder

// >>> logic/bacd_defines.svh
`ifndef BACD_DEFINES_SVH
`define BACD_DEFINES_SVH

// indirect-destination prefix byte
`define BACD_PREFIX_IND 8'h09
`define BACD_SIZE_WORD 1'b1

// register operand codes
`define BACD_F_R0L 5'h12
`define BACD_F_R0H 5'h10
`define BACD_F_R1L 5'h13
`define BACD_F_R1H 5'h11

// operand groups, upper four bits of the 5-bit field
`define BACD_GRP_IND 4'h0
`define BACD_GRP_AREG 4'h1
`define BACD_GRP_D8A 4'h2
`define BACD_GRP_D8B 4'h3
`define BACD_GRP_D16A 4'h4
`define BACD_GRP_D16B 4'h5
`define BACD_GRP_D24A 4'h6
`define BACD_GRP_ABS 4'h7
`define BACD_ABS_SHORT 1'b1

// extra operand bytes
`define BACD_EXT_S 4'h1
`define BACD_EXT_M 4'h2
`define BACD_EXT_L 4'h3

// displacement widths in bits
`define BACD_BIT_DISP_S 5'h0B
`define BACD_BIT_DISP_M 5'h13
`define BACD_BIT_DISP_L 5'h1B
`define BACD_CMP_DISP_S 5'h08
`define BACD_CMP_DISP_M 5'h10
`define BACD_CMP_DISP_L 5'h18

// base bytes, register cycles, memory cycles
`define BACD_BRK_B 4'h1
`define BACD_BRK_C 5'h11
`define BACD_BRK_VT_C 5'h02
`define BACD_BIT_B 4'h2
`define BACD_BIT_RC 5'h01
`define BACD_BIT_MC 5'h03
`define BACD_RMW_B 4'h2
`define BACD_RMW_RC 5'h02
`define BACD_RMW_MC 5'h04
`define BACD_BIT_EXOR_OP_B 4'h3
`define BACD_BIT_EXOR_OP_RC 5'h02
`define BACD_BIT_EXOR_OP_MC 5'h04
`define BACD_RANGE_LIMIT_OP_B 4'h5
`define BACD_RANGE_LIMIT_OP_RC 5'h06
`define BACD_RANGE_LIMIT_OP_MC 5'h08
`define BACD_RANGE_LIMIT_OP_W_B 4'h2
`define BACD_CMPG_B 4'h3
`define BACD_CMPG_RC 5'h01
`define BACD_CMPG_MC 5'h03
`define BACD_CMP_W_B 4'h1
`define BACD_CMPL_B 4'h6
`define BACD_CMPL_RC 5'h02
`define BACD_CMPL_MC 5'h04
`define BACD_CMPQ_B 4'h2
`define BACD_CMPQ_RC 5'h01
`define BACD_CMPQ_MC 5'h03
`define BACD_IND_B 4'h1
`define BACD_IND_C 5'h03

`endif

// >>> logic/bacd_pkg.sv
package bacd_pkg;

    typedef enum logic [3:0] {
        BACD_BREAK_TRAP,
        BACD_BIT_SET_OP,
        BACD_BIT_TEST_OP,
        BACD_BIT_TEST_CLEAR_OP,
        BACD_BIT_TEST_SET_OP,
        BACD_BIT_EXOR_OP,
        BACD_RANGE_LIMIT_OP,
        BACD_COMPARE_OP_G,
        BACD_COMPARE_OP_L,
        BACD_COMPARE_OP_Q
    } bacd_op_t;

    typedef enum logic [3:0] {
        BACD_OPND_NONE,
        BACD_OPND_DATA_REG_ZERO_LOW,
        BACD_OPND_DATA_REG_ZERO_HIGH,
        BACD_OPND_DATA_REG_ONE_LOW,
        BACD_OPND_DATA_REG_ONE_HIGH,
        BACD_OPND_REG_PAIR_TWO_ZERO,
        BACD_OPND_REG_PAIR_THREE_ONE,
        BACD_OPND_ADDR_REG_ZERO,
        BACD_OPND_ADDR_REG_ONE,
        BACD_OPND_IND_AREG,
        BACD_OPND_DISP_AREG,
        BACD_OPND_DISP_BASE,
        BACD_OPND_ABS
    } bacd_opnd_t;

    typedef struct packed {
        bacd_op_t op;
        logic word;
        logic [4:0] field;
        logic [7:0] first_byte;
        logic via_table;
        logic [3:0] quick_immediate_field;
        logic [15:0] opnd_val;
        logic [15:0] lim_lo;
        logic [15:0] lim_hi;
        logic [3:0] bit_idx;
        logic carry;
    } bacd_req_t;

    typedef struct packed {
        logic valid;
        logic illegal;
        logic [3:0] bytes;
        logic [4:0] cycles;
        logic indirect;
        logic word;
        bacd_opnd_t opnd;
        logic alt_base;
        logic [4:0] disp_bits;
        logic [7:0] quick_imm;
        logic [15:0] result;
        logic flag;
    } bacd_state_t;

endpackage : bacd_pkg

// >>> verification/bacd_decoder_tb_top.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("MISMATCH time=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end

module bacd_decoder_tb_top;
    import bacd_pkg::*;

    logic i_ref_clk;
    logic i_rst_b;
    logic i_req_valid;
    bacd_req_t i_req;
    bacd_state_t o_dec;
    int n_errors;
    int samples_checked;
    bacd_req_t r;

    bacd_decoder DUT (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_req_valid(i_req_valid),
        .i_req(i_req),
        .o_dec(o_dec)
    );

    function automatic logic is_bit(bacd_op_t op);
        return op inside {BACD_BIT_SET_OP, BACD_BIT_TEST_OP, BACD_BIT_TEST_CLEAR_OP, BACD_BIT_TEST_SET_OP,
            BACD_BIT_EXOR_OP};
    endfunction : is_bit

    // bytes, register cycles, memory cycles
    function automatic logic [13:0] base_tab(bacd_op_t op);
        case (op)
            BACD_BIT_SET_OP, BACD_BIT_TEST_OP: return {4'h2, 5'h01, 5'h03};
            BACD_BIT_TEST_CLEAR_OP, BACD_BIT_TEST_SET_OP: return {4'h2, 5'h02, 5'h04};
            BACD_BIT_EXOR_OP: return {4'h3, 5'h02, 5'h04};
            BACD_RANGE_LIMIT_OP: return {4'h5, 5'h06, 5'h08};
            BACD_COMPARE_OP_G: return {4'h3, 5'h01, 5'h03};
            BACD_COMPARE_OP_L: return {4'h6, 5'h02, 5'h04};
            default: return {4'h2, 5'h01, 5'h03};
        endcase
    endfunction : base_tab

    function automatic logic [3:0] ext_bytes(logic [4:0] f);
        case (f[4:2])
            3'b001: return 4'h1;
            3'b010: return 4'h2;
            3'b011: return (f[1:0] == 2'b11) ? 4'h2 : 4'h3;
            default: return 4'h0;
        endcase
    endfunction : ext_bytes

    function automatic logic [4:0] exp_disp(bacd_op_t op, logic [3:0] e);
        case (e)
            4'h1: return is_bit(op) ? 5'h0B : 5'h08;
            4'h2: return is_bit(op) ? 5'h13 : 5'h10;
            default: return is_bit(op) ? 5'h1B : 5'h18;
        endcase
    endfunction : exp_disp

    function automatic bacd_opnd_t exp_opnd(bacd_op_t op, logic [4:0] f);
        logic pr;
        pr = (op == BACD_COMPARE_OP_L);
        case (f)
            5'h12: return pr ? BACD_OPND_REG_PAIR_TWO_ZERO : BACD_OPND_DATA_REG_ZERO_LOW;
            5'h13: return pr ? BACD_OPND_REG_PAIR_THREE_ONE : BACD_OPND_DATA_REG_ONE_LOW;
            5'h10: return BACD_OPND_DATA_REG_ZERO_HIGH;
            5'h11: return BACD_OPND_DATA_REG_ONE_HIGH;
            5'h02: return BACD_OPND_ADDR_REG_ZERO;
            5'h03: return BACD_OPND_ADDR_REG_ONE;
            5'h00, 5'h01: return BACD_OPND_IND_AREG;
            5'h0E, 5'h0F: return BACD_OPND_ABS;
            5'h06, 5'h07, 5'h0A, 5'h0B: return BACD_OPND_DISP_BASE;
            default: return BACD_OPND_DISP_AREG;
        endcase
    endfunction : exp_opnd

    function automatic logic [15:0] clamp(logic [15:0] v, logic [15:0] lo, logic [15:0] hi);
        if ($signed(v) < $signed(lo)) return lo;
        if ($signed(v) > $signed(hi)) return hi;
        return v;
    endfunction : clamp

    function automatic bacd_req_t rand_req();
        bacd_req_t q;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        a = $urandom();
        b = $urandom();
        c = $urandom();
        q.op = bacd_op_t'(4'(c[31:16] % 16'd10));
        q.word = a[0];
        q.field = a[5:1];
        q.first_byte = a[6] ? 8'h09 : a[14:7];
        q.via_table = a[15]; // stands for software that stored the table byte
        q.quick_immediate_field = a[19:16];
        q.bit_idx = a[23:20];
        q.carry = a[24];
        q.opnd_val = b[15:0];
        q.lim_lo = b[31:16];
        q.lim_hi = c[15:0];
        // equal operands are rare otherwise
        if (a[25]) q.opnd_val = q.lim_lo;
        return q;
    endfunction : rand_req

    task automatic check(input bacd_req_t q);
        logic [13:0] t;
        logic [3:0] eb;
        logic [4:0] ec;
        logic ind;
        logic mem;
        logic bad;
        logic [15:0] v;
        logic [15:0] lo;
        logic [15:0] hi;
        t = base_tab(q.op);
        v = q.opnd_val;
        ind = (q.op inside {BACD_COMPARE_OP_G, BACD_COMPARE_OP_L, BACD_COMPARE_OP_Q}) && q.first_byte == 8'h09;
        mem = !(q.field[4:2] == 3'b100 || q.field[4:1] == 4'b0001);
        bad = q.field[4:3] == 2'b11 || q.field[4:2] == 3'b101;
        bad = bad || (q.op == BACD_COMPARE_OP_L && q.field[4:1] == 4'b1000);
        `CHK(o_dec.valid, 1'b1)
        if (q.op == BACD_BREAK_TRAP) begin
            `CHK(o_dec.bytes, 4'h1)
            `CHK(o_dec.cycles, q.via_table ? 5'h13 : 5'h11)
            return;
        end
        `CHK(o_dec.illegal, bad)
        if (bad) return;
        eb = t[13:10] + ext_bytes(q.field) + {3'b000, ind};
        if (q.word && q.op == BACD_COMPARE_OP_G) eb = eb + 4'h1;
        if (q.word && q.op == BACD_RANGE_LIMIT_OP) eb = eb + 4'h2;
        ec = (mem ? t[4:0] : t[9:5]) + (ind ? 5'h03 : 5'h00);
        `CHK(o_dec.bytes, eb)
        `CHK(o_dec.cycles, ec)
        `CHK(o_dec.indirect, ind)
        `CHK(o_dec.opnd, exp_opnd(q.op, q.field))
        if (ext_bytes(q.field) != 4'h0) `CHK(o_dec.disp_bits, exp_disp(q.op, ext_bytes(q.field)))
        if (mem && q.field[4:1] != 4'b0111) `CHK(o_dec.alt_base, q.field[0])
        if (q.op inside {BACD_COMPARE_OP_G, BACD_COMPARE_OP_Q, BACD_RANGE_LIMIT_OP}) `CHK(o_dec.word, q.word)
        if (q.op == BACD_COMPARE_OP_Q) `CHK(o_dec.quick_imm, {{4{q.quick_immediate_field[3]}}, q.quick_immediate_field})
        if (is_bit(q.op) && q.op != BACD_BIT_EXOR_OP) `CHK(o_dec.flag, v[q.bit_idx])
        if (q.op == BACD_BIT_EXOR_OP) `CHK(o_dec.flag, q.carry ^ v[q.bit_idx])
        if (q.op == BACD_BIT_TEST_CLEAR_OP) `CHK(o_dec.result, v & ~(16'h0001 << q.bit_idx))
        if (q.op inside {BACD_BIT_TEST_SET_OP, BACD_BIT_SET_OP}) `CHK(o_dec.result, v | (16'h0001 << q.bit_idx))
        // byte size works on sign-extended low bytes; the 32-bit compare on the low half
        lo = (q.op == BACD_COMPARE_OP_Q) ? {{12{q.quick_immediate_field[3]}}, q.quick_immediate_field} : q.lim_lo;
        hi = q.lim_hi;
        if (!q.word && q.op != BACD_COMPARE_OP_L) begin
            v = {{8{v[7]}}, v[7:0]};
            lo = {{8{lo[7]}}, lo[7:0]};
            hi = {{8{hi[7]}}, hi[7:0]};
        end
        if (q.op == BACD_RANGE_LIMIT_OP && $signed(lo) <= $signed(hi)) begin
            `CHK(o_dec.result, clamp(v, lo, hi))
        end
        if (q.op inside {BACD_COMPARE_OP_G, BACD_COMPARE_OP_L, BACD_COMPARE_OP_Q}) begin
            `CHK(o_dec.flag, v == lo)
            `CHK(o_dec.result, v - lo)
        end
    endtask : check

    task automatic send(input bacd_req_t q);
        i_req = q;
        i_req_valid = 1'b1;
        @(posedge i_ref_clk);
        #1;
        check(q);
    endtask : send

    task automatic idle();
        bacd_state_t p;
        p = o_dec;
        i_req_valid = 1'b0;
        i_req = rand_req();
        @(posedge i_ref_clk);
        #1;
        `CHK(o_dec.valid, 1'b0)
        `CHK(o_dec.bytes, p.bytes)
    endtask : idle

    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        i_ref_clk = 1'b0;
        forever #2 i_ref_clk = ~i_ref_clk;
    end

    initial begin
        repeat (20000) @(posedge i_ref_clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        void'($urandom(32'h0C946454));
        n_errors = 0;
        samples_checked = 0;
        i_rst_b = 1'b0;
        i_req_valid = 1'b0;
        i_req = '0;
        repeat (16) @(posedge i_ref_clk);
        #1;
        i_rst_b = 1'b1;
        `CHK(o_dec, bacd_state_t'(0))
        // every op against every operand code, back to back
        for (int o = 0; o < 10; o++) begin
            for (int f = 0; f < 32; f++) begin
                r = rand_req();
                r.op = bacd_op_t'(o[3:0]);
                r.field = f[4:0];
                r.quick_immediate_field = f[3:0];
                send(r);
            end
        end
        // reset in mid-run must clear the held answer
        i_req_valid = 1'b0;
        i_rst_b = 1'b0;
        @(posedge i_ref_clk);
        #1;
        `CHK(o_dec, bacd_state_t'(0))
        i_rst_b = 1'b1;
        for (int n = 0; n < 2000; n++) begin
            if ($urandom_range(3, 0) == 0) idle();
            send(rand_req());
        end
        idle();
        end_of_test();
    end
endmodule : bacd_decoder_tb_top
